// ==== core/dcti_pkg.sv ====
// Purpose: Constants and types for the 16K x 1 dynamic memory controller
// Assumes: Fastest speed grade, mclk at 125 MHz
// Notes: All timing counts derive from nanosecond figures at build time
// Overview of operation
// - Reads hold write select high from before column fall until after rise.
// - Reference row-to-column delay 50 ns; beyond it column access governs.
// - Shorter row-to-column delay lengthens column low time equally.
// - Write data stable at column fall, held at least 45 ns.
// - Write select low at least 45 ns, and 50 ns before strobes rise.
// - Write select and data held 95 ns after row strobe falls.
// - Read-modify-write data captured at write edge, held 45 ns after.
// - Page mode: column high 60 ns, page cycle at least 170 ns.
// - Refresh pulses row strobe with row address, column strobe high.
// - All 128 rows refreshed or accessed within every 2 ms.
// - About eight dummy cycles after power-up before real accesses.

package dcti_pkg;

	// ****************************************
	// Clock and timing figures
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_RP_NS = 100;
	localparam int T_RC_NS = 320;
	localparam int T_RCD_NS = 50;
	localparam int T_RAH_NS = 20;
	localparam int T_CAS_NS = 100;
	localparam int T_CWL_NS = 50;
	localparam int T_CP_NS = 60;
	localparam int T_PC_NS = 170;
	localparam int T_RAS_MAX_NS = 10000;
	localparam int T_INIT_NS = 3000;
	localparam int T_REFRESH_NS = 2000000;
	localparam int REFRESH_ROWS = 128;
	localparam int SYNC_STAGES = 2;
	localparam int PAGE_GUARD = 64;

	localparam int RP_I = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RC_I = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAS_I = (T_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PC_I = (T_PC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CP_I = (T_CP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [10:0] RP_CYC = 11'(RP_I);
	localparam logic [10:0] RCD_CYC =
		11'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [10:0] RAH_CYC =
		11'((T_RAH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [10:0] CAS_CYC = 11'(CAS_I);
	localparam logic [10:0] CAS_RD_CYC = 11'(CAS_I + SYNC_STAGES);
	localparam logic [10:0] WR_CYC =
		11'((T_CWL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [10:0] CAS_HIGH_CYC =
		11'((PC_I - CAS_I > CP_I) ? PC_I - CAS_I : CP_I);
	localparam logic [10:0] REF_LOW_CYC = 11'(RC_I - RP_I);
	localparam logic [10:0] RAS_MAX_CYC = 11'(T_RAS_MAX_NS / CLK_PERIOD_NS);
	localparam logic [10:0] PAGE_LIMIT = 11'(T_RAS_MAX_NS / CLK_PERIOD_NS
		- PAGE_GUARD);
	localparam logic [10:0] INIT_CYC =
		11'((T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [10:0] REFI_CYC =
		11'(T_REFRESH_NS / REFRESH_ROWS / CLK_PERIOD_NS);

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [3:0] DUMMY_CYCLES = 4'h8;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		DCTI_OP_READ,
		DCTI_OP_WRITE,
		DCTI_OP_RMW
	} dcti_op_t;

	typedef enum logic [3:0] {
		ST_INIT,
		ST_IDLE,
		ST_REF_SET,
		ST_REF_LOW,
		ST_ROW_SET,
		ST_RCD,
		ST_CAS_LOW,
		ST_RMW_WR,
		ST_CAS_HIGH,
		ST_PRE
	} dcti_state_t;

endpackage

// ==== core/dcti_refresh_timer.sv ====
// Purpose: Periodic refresh request pulse
// Assumes: One pulse per row slot of the refresh period
// Notes: Pulse is one mclk cycle wide
`timescale 1ns/1ps

module dcti_refresh_timer (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Refresh request
	output logic tick
);

	typedef struct packed {
		logic [10:0] cnt;
		logic tick;
	} dcti_tmr_t;

	dcti_tmr_t t_reg;
	dcti_tmr_t t_next;

	always_comb begin
		t_next = t_reg;
		t_next.tick = 1'b0;
		if (t_reg.cnt == 11'h000) begin
			t_next.cnt = dcti_pkg::REFI_CYC - 11'h001;
			t_next.tick = 1'b1;
		end else begin
			t_next.cnt = t_reg.cnt - 11'h001;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			t_reg <= '0;
		end else begin
			t_reg <= t_next;
		end
	end

	assign tick = t_reg.tick;

endmodule

// ==== core/dcti_ctrl.sv ====
// Purpose: Strobe sequencer for a 16K x 1 asynchronous dynamic memory
// Assumes: Memory output is tri-stated by the memory; only sampled here
// Notes: Row address is the low seven address bits
`timescale 1ns/1ps

module dcti_ctrl (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// User request
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_op,
	input wire logic [13:0] req_addr,
	input wire logic req_wdata,
	// User response
	output logic resp_valid,
	output logic resp_rdata,
	output logic init_done,
	// Memory pins
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [6:0] mem_addr,
	output logic mem_din,
	input wire logic mem_dout
);

	typedef struct packed {
		dcti_pkg::dcti_state_t state;
		logic [10:0] cnt;
		logic [10:0] ras_time;
		logic [3:0] dummy;
		logic ref_pend;
		logic [6:0] ref_row;
		dcti_pkg::dcti_op_t op;
		logic [6:0] row;
		logic [6:0] col;
		logic wdata;
		logic held;
		logic same_row;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [6:0] addr;
		logic din;
		logic rdy;
		logic rv;
		logic rd;
		logic done;
		logic s1;
		logic s2;
	} dcti_regs_t;

	dcti_regs_t r_reg;
	dcti_regs_t r_next;
	logic ref_tick;
	logic take;

	dcti_refresh_timer u_timer (
		.mclk(mclk),
		.srst(srst),
		.tick(ref_tick)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		r_next = r_reg;
		take = req_valid && r_reg.rdy;
		r_next.s1 = mem_dout;
		r_next.s2 = r_reg.s1;
		r_next.rv = 1'b0;
		if (r_reg.cnt != 11'h000) begin
			r_next.cnt = r_reg.cnt - 11'h001;
		end
		// Row-low time bounds how long a page may stay open
		r_next.ras_time = r_reg.ras_n ? 11'h000 : r_reg.ras_time + 11'h001;
		r_next.ref_pend = r_reg.ref_pend | ref_tick;
		if (take) begin
			r_next.op = dcti_pkg::dcti_op_t'(req_op);
			r_next.row = req_addr[6:0];
			r_next.col = req_addr[13:7];
			r_next.wdata = req_wdata;
			r_next.rdy = 1'b0;
		end
		unique case (r_reg.state)
			dcti_pkg::ST_INIT: begin
				// Row strobe stays high through the power-up wait
				if (r_reg.cnt == 11'h000) begin
					r_next.state = dcti_pkg::ST_IDLE;
				end
			end
			dcti_pkg::ST_IDLE: begin
				if (take) begin
					r_next.addr = req_addr[6:0];
					r_next.state = dcti_pkg::ST_ROW_SET;
				end else if (r_reg.ref_pend || r_reg.dummy != 4'h0) begin
					// Set wins over clear for a tick in this cycle
					r_next.ref_pend = ref_tick;
					if (r_reg.dummy != 4'h0) begin
						r_next.dummy = r_reg.dummy - 4'h1;
					end
					r_next.addr = r_reg.ref_row;
					r_next.rdy = 1'b0;
					r_next.state = dcti_pkg::ST_REF_SET;
				end else begin
					r_next.rdy = r_reg.done & ~r_next.ref_pend;
				end
			end
			dcti_pkg::ST_REF_SET: begin
				r_next.ras_n = 1'b0;
				r_next.cnt = dcti_pkg::REF_LOW_CYC - 11'h001;
				r_next.state = dcti_pkg::ST_REF_LOW;
			end
			dcti_pkg::ST_REF_LOW: begin
				if (r_reg.cnt == 11'h000) begin
					r_next.ras_n = 1'b1;
					r_next.ref_row = r_reg.ref_row + 7'h01;
					if (r_reg.dummy == 4'h0) begin
						r_next.done = 1'b1;
					end
					r_next.cnt = dcti_pkg::RP_CYC - 11'h001;
					r_next.state = dcti_pkg::ST_PRE;
				end
			end
			dcti_pkg::ST_ROW_SET: begin
				// Row address has had one cycle of setup
				r_next.ras_n = 1'b0;
				r_next.cnt = dcti_pkg::RCD_CYC - 11'h001;
				r_next.state = dcti_pkg::ST_RCD;
			end
			dcti_pkg::ST_RCD: begin
				if (r_reg.cnt == dcti_pkg::RCD_CYC - dcti_pkg::RAH_CYC) begin
					r_next.addr = r_reg.col;
				end
				// Column falls 56 ns after row, past the reference delay, so the plain
				// column low time is enough
				if (r_reg.cnt == 11'h000) begin
					r_next.cas_n = 1'b0;
					r_next.we_n = r_reg.op != dcti_pkg::DCTI_OP_WRITE;
					r_next.din = r_reg.wdata;
					r_next.cnt = (r_reg.op == dcti_pkg::DCTI_OP_WRITE) ?
						dcti_pkg::CAS_CYC - 11'h001 :
						dcti_pkg::CAS_RD_CYC - 11'h001;
					r_next.state = dcti_pkg::ST_CAS_LOW;
				end
			end
			dcti_pkg::ST_CAS_LOW: begin
				// Write select stays high here for reads
				if (r_reg.cnt == 11'h000) begin
					if (r_reg.op != dcti_pkg::DCTI_OP_WRITE) begin
						// Sampled past the column access time
						r_next.rd = r_reg.s2;
						r_next.rv = r_reg.op != dcti_pkg::DCTI_OP_RMW;
					end
					if (r_reg.op == dcti_pkg::DCTI_OP_RMW) begin
						// Late write after the read has been taken
						r_next.we_n = 1'b0;
						r_next.cnt = dcti_pkg::WR_CYC - 11'h001;
						r_next.state = dcti_pkg::ST_RMW_WR;
					end else begin
						// Early write: low over the whole strobe
						r_next.cas_n = 1'b1;
						r_next.we_n = 1'b1;
						// A pending refresh ends paging, so a stream of
						// requests to other rows cannot hold it off
						r_next.rdy = r_reg.ras_time < dcti_pkg::PAGE_LIMIT &&
							!r_next.ref_pend;
						r_next.held = 1'b0;
						r_next.cnt = dcti_pkg::CAS_HIGH_CYC - 11'h001;
						r_next.state = dcti_pkg::ST_CAS_HIGH;
					end
				end
			end
			dcti_pkg::ST_RMW_WR: begin
				// Data stays put through the write pulse
				if (r_reg.cnt == 11'h000) begin
					r_next.rv = 1'b1;
					r_next.cas_n = 1'b1;
					r_next.we_n = 1'b1;
					r_next.rdy = r_reg.ras_time < dcti_pkg::PAGE_LIMIT &&
						!r_next.ref_pend;
					r_next.held = 1'b0;
					r_next.cnt = dcti_pkg::CAS_HIGH_CYC - 11'h001;
					r_next.state = dcti_pkg::ST_CAS_HIGH;
				end
			end
			dcti_pkg::ST_CAS_HIGH: begin
				if (take) begin
					r_next.held = 1'b1;
					r_next.same_row = req_addr[6:0] == r_reg.row;
					if (req_addr[6:0] == r_reg.row) begin
						r_next.addr = req_addr[13:7];
					end
				end
				// Column high time also pads out the page cycle
				if (r_reg.cnt == 11'h000) begin
					r_next.rdy = 1'b0;
					if (r_next.held && r_next.same_row) begin
						r_next.held = 1'b0;
						r_next.cas_n = 1'b0;
						r_next.we_n = r_next.op != dcti_pkg::DCTI_OP_WRITE;
						r_next.din = r_next.wdata;
						r_next.cnt = (r_next.op == dcti_pkg::DCTI_OP_WRITE) ?
							dcti_pkg::CAS_CYC - 11'h001 :
							dcti_pkg::CAS_RD_CYC - 11'h001;
						r_next.state = dcti_pkg::ST_CAS_LOW;
					end else begin
						r_next.ras_n = 1'b1;
						r_next.cnt = dcti_pkg::RP_CYC - 11'h001;
						r_next.state = dcti_pkg::ST_PRE;
					end
				end
			end
			dcti_pkg::ST_PRE: begin
				if (r_reg.cnt == 11'h000) begin
					if (r_reg.held) begin
						r_next.held = 1'b0;
						r_next.addr = r_reg.row;
						r_next.state = dcti_pkg::ST_ROW_SET;
					end else begin
						r_next.rdy = r_reg.done & ~r_next.ref_pend;
						r_next.state = dcti_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				r_next.ras_n = 1'b1;
				r_next.cas_n = 1'b1;
				r_next.we_n = 1'b1;
				r_next.rdy = 1'b0;
				r_next.state = dcti_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			r_reg <= '0;
			r_reg.state <= dcti_pkg::ST_INIT;
			r_reg.cnt <= dcti_pkg::INIT_CYC - 11'h001;
			r_reg.dummy <= dcti_pkg::DUMMY_CYCLES;
			r_reg.ras_n <= 1'b1;
			r_reg.cas_n <= 1'b1;
			r_reg.we_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign req_ready = r_reg.rdy;
	assign resp_valid = r_reg.rv;
	assign resp_rdata = r_reg.rd;
	assign init_done = r_reg.done;
	assign ras_n = r_reg.ras_n;
	assign cas_n = r_reg.cas_n;
	assign we_n = r_reg.we_n;
	assign mem_addr = r_reg.addr;
	assign mem_din = r_reg.din;

endmodule

// ==== tb/dcti_ctrl_monitor.sv ====
// Purpose: Strobe timing checks on the memory side of the controller
// Assumes: mclk period 8 ns, nanosecond figures rounded up to cycles
// Notes: Counters are int so long idle spans cannot wrap
`timescale 1ns/1ps
module dcti_ctrl_monitor (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Watched pins
	input wire logic req_ready,
	input wire logic init_done,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [6:0] mem_addr,
	input wire logic mem_din
);
	// ****************
	// Helper counters
	// ****************
	int cl, ch, pc, wl, rl, rf, rh;
	always_ff @(posedge mclk) begin
		cl <= cas_n ? 0 : cl + 1;
		ch <= cas_n ? ch + 1 : 0;
		pc <= (!cas_n && cl == 0) ? 1 : pc + 1;
		wl <= we_n ? 0 : wl + 1;
		rl <= ras_n ? 0 : rl + 1;
		rh <= (srst || !ras_n) ? 0 : rh + 1;
		rf <= srst ? 0 : rf + int'(!init_done && !ras_n && rl == 0);
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	a_read_we_high: assert property (
		$fell(cas_n) && we_n |-> we_n [*7]) else $error("read we_n low");
	a_cas_low_min: assert property (
		$rose(cas_n) |-> cl >= 13) else $error("cas low too short");
	a_page_cas_high: assert property (
		$fell(cas_n) |-> ch >= 8 && pc >= 22) else $error("page timing");
	a_we_before_rise: assert property (
		$rose(cas_n) && !$past(we_n) |-> wl >= 7) else $error("we late");
	a_we_pulse_span: assert property (
		$rose(we_n) |-> wl >= 6 && rl >= 12) else $error("we too short");
	a_write_kind_ok: assert property (
		$fell(we_n) |-> cl == 0 || (cl >= 8 && rl >= 14))
		else $error("we falls in undefined window");
	a_din_hold_time: assert property (
		$fell(we_n) |=> $stable(mem_din) [*6]) else $error("din moved");
	a_row_addr_hold: assert property (
		$fell(ras_n) |-> $stable(mem_addr) [*3]) else $error("row moved");
	a_col_addr_hold: assert property (
		$fell(cas_n) |=> $stable(mem_addr) [*6]) else $error("col moved");
	a_init_dummy_cnt: assert property (
		$rose(init_done) |-> rf == 8) else $error("dummy count");
	a_no_req_early: assert property (
		!init_done |-> !req_ready) else $error("ready before init");
	a_refresh_gap: assert property (
		ras_n |-> rh < 2000) else $error("refresh gap too long");
	sequence s_ref_open;
		$fell(ras_n) && cas_n && !init_done;
	endsequence
	sequence s_col_idle;
		cas_n [*8];
	endsequence
	a_refresh_no_col: assert property (
		s_ref_open |-> s_col_idle) else $error("column strobe in refresh");
endmodule

// ==== tb/dcti_mem_model.sv ====
// Purpose: Behavioural 16K x 1 dynamic memory behind the controller
// Assumes: Fastest grade access figures
// Notes: Released output shows the inverse of the last bit, not a hold
`timescale 1ns/1ps
module dcti_mem_model (
	// Pins from the controller
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [6:0] mem_addr,
	input wire logic mem_din,
	// Data back
	output logic mem_dout
);
	logic cells [16384];
	logic [6:0] row, col;
	logic last;
	time t_ras, t_cas, d;
	initial begin
		mem_dout = 1'b0;
		last = 1'b1;
	end
	always @(negedge ras_n) begin
		row = mem_addr;
		t_ras = $time;
	end
	// Inputs settle one ns late so same-edge strobe and data never race
	always @(negedge cas_n) begin
		t_cas = $time;
		#1;
		col = mem_addr;
		if (!we_n) begin
			cells[{col, row}] = mem_din;
		end else begin
			d = (t_ras + 150 > t_cas + 100) ? t_ras + 150 - $time
				: t_cas + 100 - $time;
			#d;
			if (!cas_n) begin
				last = cells[{col, row}];
				mem_dout = last;
			end
		end
	end
	always @(negedge we_n) begin
		#1;
		if (!cas_n && $time > t_cas + 21) begin
			if ($time < t_cas + 61 || $time < t_ras + 111)
				mem_dout = 1'bx;
			else
				cells[{col, row}] = mem_din;
		end
	end
	always @(posedge cas_n) begin
		#40 mem_dout = ~last;
	end
endmodule

// ==== tb/dram_cycle_timing_interface_tb_top.sv ====
// Purpose: Self-checking bench for the dynamic memory controller
// Assumes: Memory model on the pins, mclk 8 ns
// Notes: Rows run back to back, so same-row rows go through page mode
`timescale 1ns/1ps
module dram_cycle_timing_interface_tb_top;
	// ****************
	// Bench
	// ****************
	typedef struct packed {
		logic [1:0] op;
		logic [13:0] addr;
		logic wd;
		logic exp;
	} dcti_row_t;
	logic mclk, srst, req_valid, req_ready, req_wdata, resp_valid;
	logic resp_rdata, init_done, ras_n, cas_n, we_n, mem_din, mem_dout;
	logic [1:0] req_op;
	logic [13:0] req_addr;
	logic [6:0] mem_addr;
	int error_cnt, cmp_count, cyc;
	dcti_row_t rows [11];
	dcti_ctrl dut (.mclk(mclk), .srst(srst), .req_valid(req_valid),
		.req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
		.req_wdata(req_wdata), .resp_valid(resp_valid),
		.resp_rdata(resp_rdata), .init_done(init_done), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .mem_addr(mem_addr),
		.mem_din(mem_din), .mem_dout(mem_dout));
	dcti_mem_model mem (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.mem_addr(mem_addr), .mem_din(mem_din), .mem_dout(mem_dout));
	initial begin
		mclk = 0;
		forever #4 mclk = ~mclk;
	end
	// Run needs about 4500 cycles; the ceiling leaves ample slack
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic s, input logic e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %s expected %b seen %b", nm, e, s);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic do_reset();
		srst = 1;
		repeat (3) @(posedge mclk);
		#1 srst = 0;
		chk("ras_n", ras_n, 1'b1);
		chk("cas_n", cas_n, 1'b1);
		chk("req_ready", req_ready, 1'b0);
		chk("init_done", init_done, 1'b0);
	endtask
	task automatic take(input dcti_row_t r);
		// One edge between calls, so valid never drops and rises at once
		@(posedge mclk);
		#1;
		req_op = r.op;
		req_addr = r.addr;
		req_wdata = r.wd;
		req_valid = 1;
		for (int n = 0; n < 3000 && req_ready !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		#1 req_valid = 0;
	endtask
	task automatic do_req(input dcti_row_t r);
		take(r);
		if (r.op != 2'h1) begin
			// Other row from the page window needs about 45 cycles
			for (int n = 0; n < 100 && resp_valid !== 1'b1; n++) begin
				@(posedge mclk);
				#1;
			end
			chk("resp_valid", resp_valid, 1'b1);
			chk("resp_rdata", resp_rdata, r.exp);
		end
	endtask
	initial begin
		req_valid = 0;
		req_op = 0;
		req_addr = 0;
		req_wdata = 0;
		rows = '{'{2'h1, 14'h0005, 1'b1, 1'b0},
			'{2'h1, 14'h0085, 1'b0, 1'b0}, '{2'h1, 14'h3fff, 1'b1, 1'b0},
			'{2'h0, 14'h0005, 1'b0, 1'b1}, '{2'h0, 14'h0085, 1'b0, 1'b0},
			'{2'h0, 14'h3fff, 1'b0, 1'b1}, '{2'h2, 14'h0005, 1'b0, 1'b1},
			'{2'h0, 14'h0005, 1'b0, 1'b0}, '{2'h3, 14'h3fff, 1'b0, 1'b1},
			'{2'h2, 14'h3fff, 1'b0, 1'b1}, '{2'h0, 14'h3fff, 1'b0, 1'b0}};
		do_reset();
		for (int i = 0; i < 11; i++) begin
			do_req(rows[i]);
			$display("row test %0d done", i);
		end
		// Reset in mid-column, then the cells must still hold their data
		// Page closes first, so the request opens its row from idle
		repeat (30) @(posedge mclk);
		take(rows[4]);
		repeat (12) @(posedge mclk);
		#1 do_reset();
		do_req(rows[4]);
		chk("init_done", init_done, 1'b1);
		$display("mid-cycle reset test done");
		repeat (2500) @(posedge mclk);
		#1 do_req(rows[10]);
		$display("idle refresh test done");
		stop_test();
	end
endmodule
bind dcti_ctrl dcti_ctrl_monitor u_mon (.mclk(mclk), .srst(srst),
	.req_ready(req_ready), .init_done(init_done), .ras_n(ras_n),
	.cas_n(cas_n), .we_n(we_n), .mem_addr(mem_addr), .mem_din(mem_din));
